// File: design/serial_uart_fifo_port.sv
// Serial UART with 256-character receive and transmit queues
`default_nettype none
module serial_uart_fifo_port (
  input wire logic i_clk,                  // System clock, 20 MHz
  input wire logic i_rst_b,                // Async reset, active low
  input wire uart_pkg::bus_req_t i_bus,    // Processor access
  input wire logic i_rxd,                  // Serial line from transceiver
  output logic o_txd,                      // Serial line to transceiver
  output logic [31:0] o_rdata,             // Read data, one cycle after rd
  output logic o_rdvalid,                  // Read data valid pulse
  output logic o_irq                       // Interrupt request level
);

  // -------------------------------------------------------------------
  // State and decode
  // -------------------------------------------------------------------
  uart_pkg::state_t s_r;
  uart_pkg::state_t s_nxt;

  logic rd_data;
  logic wr_data;
  logic rd_ctrl;
  logic wr_ctrl;
  logic rx_push;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic buf_take;
  logic frame_ok;
  logic rx_pend;
  logic tx_pend;
  logic [8:0] tx_free;
  logic [9:0] rx_frame;
  logic [10:0] tx_frame;
  logic [1:0] bcnt;

  assign rd_data = i_bus.rd && i_bus.addr == uart_pkg::DATA_ADDR;
  assign wr_data = i_bus.wr && i_bus.addr == uart_pkg::DATA_ADDR;
  assign rd_ctrl = i_bus.rd && i_bus.addr == uart_pkg::CTRL_ADDR;
  assign wr_ctrl = i_bus.wr && i_bus.addr == uart_pkg::CTRL_ADDR;

  // The two-entry line buffer counts against the free space, so the
  // queue and buffer together never hold more than 256 characters.
  assign tx_free = uart_pkg::DEPTH - s_r.tx_cnt - 9'(s_r.buf_cnt);

  // Pending flags follow the levels, so they drop as soon as reads or
  // writes bring the counts back to 31 or less.
  assign rx_pend = s_r.rx_irq_enable &&
    s_r.rx_cnt > uart_pkg::IRQ_LEVEL;
  assign tx_pend = s_r.we && tx_free > uart_pkg::IRQ_LEVEL;

  assign o_irq = rx_pend || tx_pend;
  assign o_txd = s_r.txd;
  assign o_rdata = s_r.rdata;
  assign o_rdvalid = s_r.rdvalid;

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    rx_push = 1'b0;
    frame_ok = 1'b0;
    rx_frame = {i_rxd, s_r.rx_sh[9:1]};
    tx_frame = '0;
    rx_pop = rd_data && s_r.rx_cnt != 9'h000;
    tx_push = wr_data && tx_free != 9'h000;
    tx_pop = s_r.tx_cnt != 9'h000 && s_r.buf_cnt != 2'h2;
    buf_take = s_r.tx_st == uart_pkg::TX_IDLE && s_r.buf_cnt != 2'h0;
    bcnt = s_r.buf_cnt;

    // Bus reads answer one cycle later; unmapped reads return zero
    s_nxt.rdvalid = i_bus.rd;
    s_nxt.rdata = '0;
    if (rd_data) begin
      if (rx_pop) begin
        s_nxt.rdata[31:uart_pkg::CNT_LSB] = {7'h00, s_r.rx_cnt - 9'h001};
        s_nxt.rdata[uart_pkg::RVALID_BIT] = 1'b1;
        s_nxt.rdata[7:0] = s_r.rx_mem[s_r.rx_rp];
      end else begin
        s_nxt.rdata[uart_pkg::RVALID_BIT] = 1'b0;
      end
    end else if (rd_ctrl) begin
      s_nxt.rdata[31:uart_pkg::CNT_LSB] = {7'h00, tx_free};
      s_nxt.rdata[uart_pkg::TX_PEND_BIT] = tx_pend;
      s_nxt.rdata[uart_pkg::RX_PEND_BIT] = rx_pend;
      s_nxt.rdata[uart_pkg::WE_BIT] = s_r.we;
      s_nxt.rdata[uart_pkg::RX_IRQ_EN_BIT] = s_r.rx_irq_enable;
    end

    if (wr_ctrl) begin
      s_nxt.rx_irq_enable = i_bus.wdata[uart_pkg::RX_IRQ_EN_BIT];
      s_nxt.we = i_bus.wdata[uart_pkg::WE_BIT];
    end

    // -----------------------------------------------------------------
    // Receiver: half-bit start check, then mid-bit samples
    // -----------------------------------------------------------------
    unique case (s_r.rx_st)
      uart_pkg::RX_IDLE: begin
        if (!i_rxd) begin
          s_nxt.rx_st = uart_pkg::RX_START;
          s_nxt.rx_div = uart_pkg::HALF_RELOAD;
        end
      end
      uart_pkg::RX_START: begin
        if (s_r.rx_div != 8'h00) begin
          s_nxt.rx_div = s_r.rx_div - 8'h01;
        end else if (!i_rxd) begin
          s_nxt.rx_st = uart_pkg::RX_DATA;
          s_nxt.rx_div = uart_pkg::BIT_RELOAD;
          s_nxt.rx_bit = 4'h0;
        end else begin
          // A glitch shorter than half a bit is not a start bit
          s_nxt.rx_st = uart_pkg::RX_IDLE;
        end
      end
      uart_pkg::RX_DATA: begin
        if (s_r.rx_div != 8'h00) begin
          s_nxt.rx_div = s_r.rx_div - 8'h01;
        end else begin
          s_nxt.rx_sh = rx_frame;
          s_nxt.rx_div = uart_pkg::BIT_RELOAD;
          s_nxt.rx_bit = s_r.rx_bit + 4'h1;
          if (s_r.rx_bit == uart_pkg::RX_LAST) begin
            s_nxt.rx_st = uart_pkg::RX_IDLE;
            // Bad parity or a low stop bit drops the character
            frame_ok = (^rx_frame[8:0]) && rx_frame[9];
          end
        end
      end
      default: s_nxt.rx_st = uart_pkg::RX_IDLE;
    endcase

    rx_push = frame_ok && s_r.rx_cnt != uart_pkg::DEPTH;

    // -----------------------------------------------------------------
    // Queues
    // -----------------------------------------------------------------
    if (rx_push) begin
      s_nxt.rx_mem[s_r.rx_wp] = rx_frame[7:0];
      s_nxt.rx_wp = s_r.rx_wp + 8'h01;
    end
    if (rx_pop) begin
      s_nxt.rx_rp = s_r.rx_rp + 8'h01;
    end
    s_nxt.rx_cnt = s_r.rx_cnt + 9'(rx_push) - 9'(rx_pop);

    if (tx_push) begin
      s_nxt.tx_mem[s_r.tx_wp] = i_bus.wdata[7:0];
      s_nxt.tx_wp = s_r.tx_wp + 8'h01;
    end
    if (tx_pop) begin
      s_nxt.tx_rp = s_r.tx_rp + 8'h01;
    end
    s_nxt.tx_cnt = s_r.tx_cnt + 9'(tx_push) - 9'(tx_pop);

    // Two-entry buffer: the queue refills it while a frame is on the
    // line, so the shifter starts the next frame after one idle clock.
    if (buf_take) begin
      s_nxt.buf_q[0] = s_r.buf_q[1];
      bcnt = bcnt - 2'h1;
    end
    if (tx_pop) begin
      s_nxt.buf_q[bcnt[0]] = s_r.tx_mem[s_r.tx_rp];
      bcnt = bcnt + 2'h1;
    end
    s_nxt.buf_cnt = bcnt;

    // -----------------------------------------------------------------
    // Transmitter
    // -----------------------------------------------------------------
    unique case (s_r.tx_st)
      uart_pkg::TX_IDLE: begin
        s_nxt.txd = 1'b1;
        if (buf_take) begin
          tx_frame = {1'b1, ~^s_r.buf_q[0], s_r.buf_q[0], 1'b0};
          s_nxt.tx_sh = tx_frame;
          s_nxt.txd = tx_frame[0];
          s_nxt.tx_st = uart_pkg::TX_SEND;
          s_nxt.tx_div = uart_pkg::BIT_RELOAD;
          s_nxt.tx_bit = 4'h0;
        end
      end
      uart_pkg::TX_SEND: begin
        if (s_r.tx_div != 8'h00) begin
          s_nxt.tx_div = s_r.tx_div - 8'h01;
        end else if (s_r.tx_bit == uart_pkg::TX_LAST) begin
          s_nxt.tx_st = uart_pkg::TX_IDLE;
          s_nxt.txd = 1'b1;
        end else begin
          s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
          s_nxt.txd = s_r.tx_sh[1];
          s_nxt.tx_bit = s_r.tx_bit + 4'h1;
          s_nxt.tx_div = uart_pkg::BIT_RELOAD;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r <= '0;
      s_r.txd <= 1'b1;
      s_r.rx_irq_enable <= uart_pkg::RX_IRQ_EN_RST;
      s_r.we <= uart_pkg::WE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence start_bit_s;
    !o_txd ##173 !o_txd;
  endsequence

  sequence frame_loaded_s;
    (^s_r.tx_sh[9:1]) && s_r.tx_sh[10] && !s_r.tx_sh[0];
  endsequence

  start_bit_len_a: assert property (
    buf_take |=> start_bit_s)
    else $error("start bit not held for one bit period");

  tx_frame_fmt_a: assert property (
    buf_take |=> frame_loaded_s)
    else $error("frame lacks odd parity or framing bits");

  first_bit_lsb_a: assert property (
    buf_take |=> ##174 (o_txd == $past(s_r.buf_q[0][0], 175)))
    else $error("first data bit is not the LSB");

  rx_cap_a: assert property (
    s_r.rx_cnt <= uart_pkg::DEPTH)
    else $error("receive count beyond capacity");

  rx_full_drop_a: assert property (
    s_r.rx_cnt == uart_pkg::DEPTH && !rd_data |=>
      s_r.rx_cnt == uart_pkg::DEPTH && s_r.rx_wp == $past(s_r.rx_wp))
    else $error("character stored into full receive queue");

  data_read_a: assert property (
    rd_data && s_r.rx_cnt != 9'h000 |=> o_rdvalid && o_rdata[15] &&
      o_rdata[31:16] == 16'($past(s_r.rx_cnt) - 9'h001))
    else $error("data read count or valid flag wrong");

  empty_read_a: assert property (
    rd_data && s_r.rx_cnt == 9'h000 |=> !o_rdata[15] &&
      s_r.rx_rp == $past(s_r.rx_rp))
    else $error("empty read moved queue or set valid");

  write_no_rx_a: assert property (
    wr_data && !i_bus.rd && !rx_push |=> $stable(s_r.rx_cnt))
    else $error("data write disturbed receive queue");

  tx_full_drop_a: assert property (
    wr_data && tx_free == 9'h000 |=> s_r.tx_wp == $past(s_r.tx_wp))
    else $error("character stored into full transmit queue");

  ctrl_free_a: assert property (
    rd_ctrl |=> o_rdata[31:16] == 16'($past(tx_free)))
    else $error("free space field wrong");

  rx_irq_a: assert property (
    s_r.rx_irq_enable && s_r.rx_cnt > uart_pkg::IRQ_LEVEL |-> o_irq)
    else $error("receive interrupt missing");

  tx_irq_a: assert property (
    s_r.we && tx_free > uart_pkg::IRQ_LEVEL |-> o_irq)
    else $error("transmit interrupt missing");

  irq_quiet_a: assert property (
    !s_r.rx_irq_enable && !s_r.we |-> !o_irq)
    else $error("interrupt raised while both enables are off");

  rx_pend_bit_a: assert property (
    rd_ctrl && s_r.rx_irq_enable && s_r.rx_cnt > uart_pkg::IRQ_LEVEL
      |=> o_rdata[uart_pkg::RX_PEND_BIT])
    else $error("receive pending flag not shown");

  tx_pend_bit_a: assert property (
    rd_ctrl && s_r.we && tx_free > uart_pkg::IRQ_LEVEL
      |=> o_rdata[uart_pkg::TX_PEND_BIT])
    else $error("transmit pending flag not shown");

  unmapped_rd_a: assert property (
    i_bus.rd && !rd_data && !rd_ctrl |=> o_rdvalid && o_rdata == 32'h0)
    else $error("unmapped read returned data");

  tx_cap_a: assert property (
    {1'b0, s_r.tx_cnt} + 10'(s_r.buf_cnt) <= 10'(uart_pkg::DEPTH))
    else $error("transmit side holds more than its capacity");

  buf_bound_a: assert property (
    s_r.buf_cnt != 2'h3)
    else $error("line buffer count out of range");

  tx_store_a: assert property (
    wr_data && tx_free != 9'h000 |=>
      s_r.tx_mem[$past(s_r.tx_wp)] == $past(i_bus.wdata[7:0]))
    else $error("written character not stored");

  rx_bad_drop_a: assert property (
    s_r.rx_st == uart_pkg::RX_DATA && s_r.rx_div == 8'h00 &&
      s_r.rx_bit == uart_pkg::RX_LAST && !(^rx_frame[8:0])
      |=> s_r.rx_wp == $past(s_r.rx_wp))
    else $error("character with bad parity stored");

  tx_idle_high_a: assert property (
    s_r.tx_st == uart_pkg::TX_IDLE |-> o_txd)
    else $error("line not high while transmitter idle");

  stop_bit_a: assert property (
    s_r.tx_st == uart_pkg::TX_SEND && s_r.tx_bit == uart_pkg::TX_LAST
      |-> o_txd)
    else $error("stop bit not high");

endmodule // serial_uart_fifo_port
`default_nettype wire

// File: design/uart_pkg.sv
// Constants and carrier types for the serial UART with character queues
`default_nettype none
package uart_pkg;
  // -------------------------------------------------------------------
  // Register map and fields
  // -------------------------------------------------------------------
  localparam logic [31:0] DATA_ADDR = 32'h1000_1010;
  localparam logic [31:0] CTRL_ADDR = 32'h1000_1014;
  localparam int CNT_LSB = 16;
  localparam int RVALID_BIT = 15;
  localparam int RX_IRQ_EN_BIT = 0;
  localparam int WE_BIT = 1;
  localparam int RX_PEND_BIT = 8;
  localparam int TX_PEND_BIT = 9;
  localparam logic RX_IRQ_EN_RST = 1'b0;
  localparam logic WE_RST = 1'b0;

  // -------------------------------------------------------------------
  // Queues and line timing
  // -------------------------------------------------------------------
  localparam logic [8:0] DEPTH = 9'h100;
  localparam logic [8:0] IRQ_LEVEL = 9'h01F;
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_RATE = 115_200;
  // Nearest whole cycle count: 174 clocks per bit, 0.2 % slow
  localparam int BIT_CYC = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam logic [7:0] BIT_RELOAD = 8'(BIT_CYC - 1);
  localparam logic [7:0] HALF_RELOAD = 8'(BIT_CYC / 2 - 1);
  localparam logic [3:0] TX_LAST = 4'hA;
  localparam logic [3:0] RX_LAST = 4'h9;

  // -------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;

  typedef struct packed {
    logic [255:0][7:0] rx_mem;
    logic [7:0] rx_wp;
    logic [7:0] rx_rp;
    logic [8:0] rx_cnt;
    logic [255:0][7:0] tx_mem;
    logic [7:0] tx_wp;
    logic [7:0] tx_rp;
    logic [8:0] tx_cnt;
    logic [1:0][7:0] buf_q;
    logic [1:0] buf_cnt;
    tx_state_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_bit;
    logic [7:0] tx_div;
    logic txd;
    rx_state_t rx_st;
    logic [9:0] rx_sh;
    logic [3:0] rx_bit;
    logic [7:0] rx_div;
    logic rx_irq_enable;
    logic we;
    logic [31:0] rdata;
    logic rdvalid;
  } state_t;
endpackage
`default_nettype wire

// File: verification/line_partner.sv
// Behavioural model of the line transceiver facing the UART
`default_nettype none
module line_partner (
  input wire logic i_clk,  // System clock
  input wire logic i_txd,  // Line from the UART transmitter
  output logic o_rxd       // Line into the UART receiver
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  int errs;

  initial begin
    o_rxd = 1'b1;
    errs = 0;
  end

  // -------------------------------------------------------------------
  // Sender: whole frames at the line rate, optional bad parity
  // -------------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, (~^d) ^ bad, d, 1'b0};
    @(posedge i_clk);
    for (int i = 0; i < 11; i++) begin
      o_rxd <= f[i];
      repeat (uart_pkg::BIT_CYC) @(posedge i_clk);
    end
  endtask

  // -------------------------------------------------------------------
  // Decoder: samples mid-bit, flags framing or parity faults
  // -------------------------------------------------------------------
  always begin
    logic [9:0] f;
    @(negedge i_txd);
    repeat (uart_pkg::BIT_CYC / 2) @(posedge i_clk);
    if (i_txd !== 1'b0) errs++;
    for (int i = 0; i < 10; i++) begin
      repeat (uart_pkg::BIT_CYC) @(posedge i_clk);
      f[i] = i_txd;
    end
    if (f[9] !== 1'b1 || (^f[8:0]) !== 1'b1) errs++;
    got.push_back(f[7:0]);
  end
endmodule // line_partner
`default_nettype wire

// File: verification/tb_top.sv
// Register-level testbench for the serial UART with character queues
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst_b;
  uart_pkg::bus_req_t i_bus;
  logic i_rxd;
  logic o_txd;
  logic [31:0] o_rdata;
  logic o_rdvalid;
  logic o_irq;
  int fails = 0;
  int samples_checked = 0;
  localparam logic [31:0] DA = uart_pkg::DATA_ADDR;
  localparam logic [31:0] CA = uart_pkg::CTRL_ADDR;

  always #25 i_clk = ~i_clk;

  serial_uart_fifo_port u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_bus(i_bus), .i_rxd(i_rxd), .o_txd(o_txd), .o_rdata(o_rdata),
    .o_rdvalid(o_rdvalid), .o_irq(o_irq));
  line_partner u_line (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd));

  // -------------------------------------------------------------------
  // Checking and bus tasks
  // -------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic r, input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    i_bus <= '{rd: r, wr: w, addr: a, wdata: d};
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b0, 1'b1, a, d);
    bus(1'b0, 1'b0, 32'h0, 32'h0);
  endtask

  // Answer lands one edge after the request; look just past that edge
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b1, 1'b0, a, 32'h0);
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    #1;
    chk({31'h0, o_rdvalid}, 32'h1);
    chk(o_rdata, exp);
  endtask

  task automatic wait_got(input int n);
    for (int k = 0; k < 4000 && u_line.got.size() < n; k++) @(posedge i_clk);
  endtask

  task automatic report_and_stop;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is about 11.4k cycles; allow more than double
  initial begin
    repeat (30000) @(posedge i_clk);
    fails++;
    report_and_stop;
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    i_bus = '0;
    i_rst_b = 1'b0;
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(DA, 32'h0);
    rd(CA, 32'h0100_0000);
    rd(32'h1000_1018, 32'h0);
    @(posedge i_clk);
    #1 chk({31'h0, o_rdvalid}, 32'h0);
    wr(CA, 32'h3);
    rd(CA, 32'h0100_0203);
    chk({31'h0, o_irq}, 32'h1);
    wr(CA, 32'h0);
    #1 chk({31'h0, o_irq}, 32'h0);
    u_line.send(8'hA5, 1'b0);
    u_line.send(8'hC3, 1'b1);
    u_line.send(8'h3C, 1'b0);
    wr(DA, 32'h55);
    rd(DA, 32'h0001_80A5);
    rd(DA, 32'h0000_803C);
    rd(DA, 32'h0);
    wait_got(1);
    chk({24'h0, u_line.got[0]}, 32'h55);
    // Back-to-back writes overrun the queue while one char is on the line
    for (int i = 0; i < 258; i++) bus(1'b0, 1'b1, DA, 32'(i));
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    wr(CA, 32'h2);
    rd(CA, 32'h0000_0002);
    chk({31'h0, o_irq}, 32'h0);
    wait_got(3);
    chk({24'h0, u_line.got[1]}, 32'h0);
    chk({24'h0, u_line.got[2]}, 32'h1);
    chk(32'(u_line.got.size()), 32'h3);
    chk(32'(u_line.errs), 32'h0);
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
